//--- pkg/iflg_map.vh
// constants and register map of the pending interrupt flag block
// Behaviour
// - bit 15 two-wire serial, bit 14 serial peripheral, bit 13 remote controller causes.
// - bit 12 uart, bits 11..9 wide timer ch2..ch0, bit 8 byte timer.
// - bit 7 pwm capture, bit 6 display, bit 5 supply detect, bit 4 slow timer.
// - bit 3 clock timer, bit 2 stopwatch, bit 1 port 1 input.
// - flag reads 1 when cause occurred, 0 otherwise; all flags zero after reset.
// - upper byte flags clear on software write of one.
// - lower byte flags clear on write of one only in pulse trigger mode.
// - level mode lower flags ignore writes and follow the source level.
// - bit 0 port 0 input cause, same behaviour as other lower flags.
`ifndef IFLG_MAP_VH
`define IFLG_MAP_VH
`define IFLG_ADDR_FLAGS 16'h4300
`define IFLG_ADDR_MASK 16'h4304
`define IFLG_ADDR_TRIG 16'h4308
`define IFLG_W 16
`define IFLG_INT_HI 15
`define IFLG_INT_LO 8
`define IFLG_EXT_HI 7
`define IFLG_EXT_LO 0
`define IFLG_RST_FLAGS 16'h0000
`define IFLG_RST_MASK 16'h0000
`define IFLG_RST_TRIG 8'h00
`define IFLG_ZERO32 32'h00000000
`endif

//--- rtl/iflg_apb_slave.v
// apb write/read strobe decode for the flag block
`timescale 1ns/100ps
module iflg_apb_slave (
  input wire psel,
  input wire penable,
  input wire pwrite,
  output wire pready,
  output wire pslverr,
  output wire wrStb,
  output wire rdStb
);
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign wrStb = psel & penable & pwrite;
  assign rdStb = psel & ~penable & ~pwrite;
endmodule // iflg_apb_slave

//--- rtl/iflg_flag_bit.v
// one pending flag cell with set-over-clear and level follow
`timescale 1ns/100ps
`include "iflg_map.vh"
module iflg_flag_bit (
  input wire clk,
  input wire rst,
  input wire cause,
  input wire levelMode,
  input wire clrReq,
  output reg flag_r
);
  always @(posedge clk or posedge rst) begin
    if (rst)
      flag_r <= 1'b0;
    else if (levelMode)
      flag_r <= cause;
    else if (cause)
      flag_r <= 1'b1;
    else if (clrReq)
      flag_r <= 1'b0;
  end
endmodule // iflg_flag_bit

//--- rtl/iflg_top.v
// pending interrupt flag register with apb access and interrupt output
//
// The implementer's own choice: register access over APB.
`timescale 1ns/100ps
`include "iflg_map.vh"
module iflg_top (
  input wire clk,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [15:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire [15:0] causeIn,
  output wire irq
);
  // ==========================================
  // bus decode
  wire wrStb;
  wire rdStb;
  reg [15:0] mask_r;
  reg [7:0] trigLevel_r;
  wire [15:0] pendingFlags;
  wire [15:0] clrReq;

  function hit;
    input [15:0] a;
    input [15:0] b;
    begin
      hit = (a == b);
    end
  endfunction

  iflg_apb_slave uBus (
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .pready(pready),
    .pslverr(pslverr),
    .wrStb(wrStb),
    .rdStb(rdStb)
  );

  // ==========================================
  // flag cells
  assign clrReq = (wrStb && hit(paddr, `IFLG_ADDR_FLAGS)) ? pwdata[15:0] : 16'h0000;
  genvar i;
  generate
    for (i = 0; i < `IFLG_W; i = i + 1) begin : gFlag
      if (i >= `IFLG_INT_LO) begin : gInt
        iflg_flag_bit uBit (
          .clk(clk),
          .rst(rst),
          .cause(causeIn[i]),
          .levelMode(1'b0),
          .clrReq(clrReq[i]),
          .flag_r(pendingFlags[i])
        );
      end else begin : gExt
        iflg_flag_bit uBit (
          .clk(clk),
          .rst(rst),
          .cause(causeIn[i]),
          .levelMode(trigLevel_r[i]),
          .clrReq(clrReq[i] & ~trigLevel_r[i]),
          .flag_r(pendingFlags[i])
        );
      end
    end
  endgenerate

  // ==========================================
  // control registers
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      mask_r <= `IFLG_RST_MASK;
      trigLevel_r <= `IFLG_RST_TRIG;
    end else if (wrStb) begin
      if (hit(paddr, `IFLG_ADDR_MASK))
        mask_r <= pwdata[15:0];
      if (hit(paddr, `IFLG_ADDR_TRIG))
        trigLevel_r <= pwdata[7:0];
    end
  end

  // ==========================================
  // read data
  always @(posedge clk or posedge rst) begin
    if (rst)
      prdata <= `IFLG_ZERO32;
    else if (rdStb) begin
      if (hit(paddr, `IFLG_ADDR_FLAGS))
        prdata <= {16'h0000, pendingFlags};
      else if (hit(paddr, `IFLG_ADDR_MASK))
        prdata <= {16'h0000, mask_r};
      else if (hit(paddr, `IFLG_ADDR_TRIG))
        prdata <= {24'h000000, trigLevel_r};
      else
        prdata <= `IFLG_ZERO32;
    end
  end

  assign irq = |(pendingFlags & mask_r);
endmodule // iflg_top

//--- testbench/iflg_cause_src.sv
// model of the peripheral cause sources
`timescale 1ns/100ps
module iflg_cause_src (
  input wire clk,
  input wire [15:0] pat,
  output reg [15:0] causeIn
);
  initial causeIn = 16'h0000;
  always @(posedge clk) causeIn <= pat;
endmodule // iflg_cause_src

//--- testbench/iflg_properties.sv
// port checker for the flag block
`timescale 1ns/100ps
module iflg_props (
  input wire clk,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [15:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire [15:0] causeIn,
  input wire irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence rdS; psel && !penable && !pwrite; endsequence
  sequence rdF; rdS ##0 paddr == 16'h4300; endsequence
  a_ready_high: assert property (pready && !pslverr) else $error("ready");
  a_reset_quiet: assert property ($fell(rst) |-> !irq && prdata == 0) else $error("rst");
  a_hi_latch: assert property (rdF |=>
    (prdata[15:8] & $past(causeIn[15:8], 2)) == $past(causeIn[15:8], 2)) else $error("hi");
  a_lo_latch: assert property (rdF |=>
    (prdata[7:0] & $past(causeIn[7:0], 2)) == $past(causeIn[7:0], 2)) else $error("lo");
  a_unmapped_zero: assert property (rdS ##0 paddr == 16'h4310 |=> prdata == 0) else $error("um");
  a_upper_zero: assert property (rdS |=> prdata[31:16] == 0) else $error("up");
  a_hold_data: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
    else $error("hold");
  a_mask_off: assert property (psel && penable && pwrite && paddr == 16'h4304 &&
    pwdata[15:0] == 0 |=> !irq) else $error("mask");
endmodule // iflg_props
bind iflg_top iflg_props iflg_props_inst(.*);

//--- testbench/tb_iflg_top.sv
// self-checking bench for the flag block
`timescale 1ns/100ps
module tb_iflg_top;
  reg clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
  reg [15:0] paddr = 16'h0000, pat = 16'h0000;
  reg [31:0] pwdata = 32'h00000000, rd;
  wire [31:0] prdata;
  wire [15:0] causeIn;
  wire pready, pslverr, irq;
  integer errors = 0, total_checks = 0, cyc = 0;
  iflg_top iflg_top_inst(.*);
  iflg_cause_src iflg_cause_src_inst(.*);
  initial forever #5 clk = ~clk;
  task results; begin
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  end endtask
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc > 2000) begin errors = errors + 1; results; end
  end
  task chk(input [31:0] g, input [31:0] e); begin
    total_checks = total_checks + 1;
    if (g !== e) begin errors = errors + 1; $display("[ERR] %0t %h %h", $time, g, e); end
  end endtask
  task apb(input w, input [15:0] a, input [31:0] d); begin
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk) penable <= 1;
    @(posedge clk) while (pready !== 1'b1) @(posedge clk);
    rd = prdata; psel <= 0; penable <= 0;
    @(posedge clk);
  end endtask
  task rdc(input [15:0] a, input [31:0] e); begin apb(0, a, 0); chk(rd, e); end endtask
  task pulse(input [15:0] v); begin pat <= v; @(posedge clk) pat <= 0; @(posedge clk); end endtask
  task t_reset; begin rdc(16'h4300, 0); rdc(16'h4304, 0); rdc(16'h4308, 0); end endtask
  task t_upper; begin
    pulse(16'hFF00); rdc(16'h4300, 32'h0000FF00);
    apb(1, 16'h4300, 32'h00005500); rdc(16'h4300, 32'h0000AA00);
    apb(1, 16'h4300, 32'h0000FF00); rdc(16'h4300, 0);
  end endtask
  task t_lower; begin
    pulse(16'h00FF); rdc(16'h4300, 32'h000000FF);
    apb(1, 16'h4300, 32'h000000FF); rdc(16'h4300, 0);
  end endtask
  task t_level; begin
    apb(1, 16'h4308, 32'h0000000F); pat <= 16'h000F; repeat (2) @(posedge clk);
    apb(1, 16'h4300, 32'h0000000F); rdc(16'h4300, 32'h0000000F);
    pat <= 0; repeat (3) @(posedge clk); rdc(16'h4300, 0);
    apb(1, 16'h4308, 0);
  end endtask
  task t_irq; begin
    apb(1, 16'h4304, 32'h00008000); pulse(16'h8000); @(posedge clk); chk(irq, 1);
    apb(1, 16'h4304, 0); chk(irq, 0); apb(1, 16'h4300, 32'h00008000); rdc(16'h4310, 0);
  end endtask
  task t_midreset; begin
    apb(1, 16'h4304, 32'h0000FFFF); pulse(16'h0101); @(posedge clk); chk(irq, 1);
    rst <= 1; repeat (3) @(posedge clk); rst <= 0; @(posedge clk);
    chk(irq, 0); rdc(16'h4300, 0); rdc(16'h4304, 0);
  end endtask
  initial begin
    repeat (20) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    t_reset; t_upper; t_lower; t_level; t_irq; t_midreset;
    results;
  end
endmodule // tb_iflg_top
